// >>> core/sdb_regs.svh
// Mode register fields and timing constants of the SDRAM core
`ifndef SDB_REGS_SVH
`define SDB_REGS_SVH
`define SDB_MODE_W      13
`define SDB_MODE_RESET  13'h0020
`define SDB_BL_MSB      2
`define SDB_BT_BIT      3
`define SDB_CL_MSB      6
`define SDB_CL_LSB      4
`define SDB_OP_MSB      12
`define SDB_OP_LSB      7
`define SDB_OP_SINGLE   6'h01
`define SDB_BL_1        3'h0
`define SDB_BL_2        3'h1
`define SDB_BL_4        3'h2
`define SDB_BL_8        3'h3
`define SDB_BL_FULL     3'h7
`define SDB_CL_3        3'h3
`define SDB_AP_BIT      10
`define SDB_COL_TOP_BIT 11
`define SDB_CLK_NS      5
`define SDB_WR_TIME_NS  15
`define SDB_WR_CYC      ((`SDB_WR_TIME_NS + `SDB_CLK_NS - 1) / `SDB_CLK_NS)
`define SDB_REC_W       2
`define SDB_DQZ_LAT     2
`endif

// >>> core/sdb_pkg.sv
// Types shared by the SDRAM core files
package sdb_pkg;
   typedef enum logic [1:0] {PWR_RUN, PWR_DOWN, PWR_SELF} sdb_pwr_t;
   typedef logic [1:0] sdb_bank_t;
endpackage : sdb_pkg

// >>> core/sdb_fifo.sv
// Write data buffer between the data pins and the storage array
`timescale 1ns/1ps
module sdb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   // Fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic [AW:0]      wrPtr_r;
   logic [AW:0]      rdPtr_r;
   wire              push = inValid && inReady;
   wire              pop  = outValid && outReady;

   assign inReady  = (wrPtr_r - rdPtr_r) != FULL_CNT;
   assign outValid = wrPtr_r != rdPtr_r;
   assign outData  = store[rdPtr_r[AW-1:0]];

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         if (push) wrPtr_r <= wrPtr_r + 1'b1;
         if (pop) rdPtr_r <= rdPtr_r + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) store[wrPtr_r[AW-1:0]] <= inData;
   end
endmodule : sdb_fifo

// >>> core/sdb_core.sv
// Command core of a four-bank synchronous DRAM
`timescale 1ns/1ps
`include "sdb_regs.svh"
module sdb_core #(
   parameter int ROW_W     = 13,
   parameter int COL_W     = 11,
   parameter int DQ_W      = 8,
   parameter int ROW_KEEP  = 2,
   parameter int BUF_DEPTH = 16
) (
   // Clock and reset
   input  wire logic               sys_clk,
   input  wire logic               reset_n,
   // Command pins
   input  wire logic               cke,
   input  wire logic               chipSel_n,
   input  wire logic               rowStrobe_n,
   input  wire logic               colStrobe_n,
   input  wire logic               writeSel_n,
   input  wire logic               dataMask,
   input  sdb_pkg::sdb_bank_t      bankSelectBits,
   input  wire logic [ROW_W-1:0]   addrPins,
   // Data pins
   input  wire logic [DQ_W-1:0]    dqIn,
   output logic [DQ_W-1:0]         dqOut,
   output logic                    dqOe,
   // Status
   output logic                    wrBufReady,
   output logic [3:0]              bankOpen,
   output logic [`SDB_MODE_W-1:0]  operatingModeSetup,
   output logic [ROW_W+1:0]        refreshCount,
   output sdb_pkg::sdb_pwr_t       powerState
);
   import sdb_pkg::*;

   localparam int MEM_AW = 2 + ROW_KEEP + COL_W;
   localparam int WR_CYC = `SDB_WR_CYC;
   localparam int DQZ    = `SDB_DQZ_LAT;
   // Output enable is a register, so the off state is seen one edge later
   localparam int DQZ_SEEN = DQZ + 1;
   localparam logic [ROW_W+1:0] REF_ONE = 1;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [COL_W-1:0] colAt(
      input logic [COL_W-1:0] start, input logic [COL_W-1:0] idx,
      input logic [2:0] bl, input logic il);
      logic [COL_W-1:0] m;
      logic [COL_W-1:0] s;
      m = '0;
      s = il ? (start ^ idx) : (start + idx);
      if (bl == `SDB_BL_2) m = COL_W'(1);
      else if (bl == `SDB_BL_4) m = COL_W'(3);
      else if (bl == `SDB_BL_8) m = COL_W'(7);
      else if (bl == `SDB_BL_FULL) m = '1;
      colAt = (start & ~m) | (s & m);
   endfunction : colAt

   function automatic logic [COL_W-1:0] lenOf(input logic [2:0] bl);
      lenOf = COL_W'(1);
      if (bl == `SDB_BL_2) lenOf = COL_W'(2);
      else if (bl == `SDB_BL_4) lenOf = COL_W'(4);
      else if (bl == `SDB_BL_8) lenOf = COL_W'(8);
   endfunction : lenOf

   function automatic logic [MEM_AW-1:0] memIdx(input logic [1:0] b,
      input logic [ROW_W-1:0] r, input logic [COL_W-1:0] c);
      memIdx = {b, r[ROW_KEEP-1:0], c};
   endfunction : memIdx

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [`SDB_MODE_W-1:0] modeReg_r;
   logic                   ckePrev_r;
   sdb_pwr_t               pwr_r;
   sdb_pwr_t               pwr_nxt;
   logic [3:0]             bankOpen_r;
   logic [ROW_W-1:0]       actRow_r [0:3];
   logic [ROW_W+1:0]       refRow_r;
   logic                   bActive_r;
   logic                   bWrite_r;
   logic                   bAp_r;
   logic [1:0]             bBank_r;
   logic [COL_W-1:0]       bStart_r;
   logic [COL_W-1:0]       bIdx_r;
   logic [`SDB_REC_W-1:0]  wrRec_r [0:3];
   logic [DQ_W-1:0]        pipe0_r;
   logic [DQ_W-1:0]        pipe1_r;
   logic                   vld0_r;
   logic                   vld1_r;
   logic [DQ_W-1:0]        dqOut_r;
   logic                   outVld_r;
   logic                   dqOe_r;
   logic                   dqmD1_r;
   logic                   dqmD2_r;
   logic [DQ_W-1:0]        mem [0:2**MEM_AW-1];

   // -----------------------------------------------------------------
   // Command decode
   // -----------------------------------------------------------------
   wire cmdLive = ckePrev_r && !chipSel_n && pwr_r == PWR_RUN;
   wire isAct  = cmdLive && !rowStrobe_n && colStrobe_n && writeSel_n;
   wire isRd   = cmdLive && rowStrobe_n && !colStrobe_n && writeSel_n;
   wire isWr   = cmdLive && rowStrobe_n && !colStrobe_n && !writeSel_n;
   wire isPre  = cmdLive && !rowStrobe_n && colStrobe_n && !writeSel_n;
   wire isMrs  = cmdLive && !rowStrobe_n && !colStrobe_n && !writeSel_n;
   wire isRef  = cmdLive && !rowStrobe_n && !colStrobe_n && writeSel_n;
   wire isStop = cmdLive && rowStrobe_n && colStrobe_n && !writeSel_n;
   wire isARef = isRef && cke;
   wire isSRef = isRef && !cke;
   wire rwCmd  = isRd || isWr;
   wire apFlag = addrPins[`SDB_AP_BIT];
   wire [COL_W-1:0] colIn = COL_W'({addrPins[`SDB_COL_TOP_BIT],
                                    addrPins[`SDB_AP_BIT-1:0]});

   // Mode fields
   wire [2:0] blCode = modeReg_r[`SDB_BL_MSB:0];
   wire interleaved = modeReg_r[`SDB_BT_BIT];
   wire latency3 = modeReg_r[`SDB_CL_MSB:`SDB_CL_LSB] == `SDB_CL_3;
   wire singleWrite =
      modeReg_r[`SDB_OP_MSB:`SDB_OP_LSB] == `SDB_OP_SINGLE;

   // -----------------------------------------------------------------
   // Burst engine
   // -----------------------------------------------------------------
   wire oneBeatWr = isWr && (singleWrite || blCode == `SDB_BL_1);
   wire wrSingle = bWrite_r && singleWrite;
   wire fullPage = blCode == `SDB_BL_FULL && !wrSingle;
   wire [COL_W-1:0] effLen = wrSingle ? COL_W'(1) : lenOf(blCode);
   wire bLast = !fullPage && bIdx_r == effLen - COL_W'(1);
   wire beatNow = bActive_r && ckePrev_r;
   wire [COL_W-1:0] curCol = colAt(bStart_r, bIdx_r, blCode, interleaved);
   wire stopHit = isStop ||
                  (isPre && (apFlag || bankSelectBits == bBank_r));
   wire bActive_nxt = rwCmd ? !oneBeatWr :
                      (stopHit || (beatNow && bLast)) ? 1'b0 : bActive_r;
   wire [COL_W-1:0] bIdx_nxt = rwCmd ? (isWr ? COL_W'(1) : '0) :
                               beatNow ? bIdx_r + COL_W'(1) : bIdx_r;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         bActive_r <= 1'b0;
         bWrite_r  <= 1'b0;
         bAp_r     <= 1'b0;
         bBank_r   <= '0;
         bStart_r  <= '0;
         bIdx_r    <= '0;
      end else begin
         bActive_r <= bActive_nxt;
         bIdx_r    <= bIdx_nxt;
         if (rwCmd) begin
            bWrite_r <= isWr;
            bAp_r    <= apFlag;
            bBank_r  <= bankSelectBits;
            bStart_r <= colIn;
         end
      end
   end

   // -----------------------------------------------------------------
   // Bank state and auto precharge
   // -----------------------------------------------------------------
   wire [3:0] oldHot = 4'h1 << bBank_r;
   wire [3:0] newHot = 4'h1 << bankSelectBits;
   // Interrupting burst ends an auto-precharged one as if complete
   wire apEndOld = bActive_r && bAp_r && (rwCmd || (beatNow && bLast));
   wire [3:0] rdApClose = (apEndOld && !bWrite_r) ? oldHot : 4'h0;
   wire [3:0] recStart = ((apEndOld && bWrite_r) ? oldHot : 4'h0) |
                         ((oneBeatWr && apFlag) ? newHot : 4'h0);
   wire [3:0] preClose = isPre ? (apFlag ? 4'hF : newHot) : 4'h0;
   logic [3:0] recDone;
   wire [3:0] bankOpen_nxt = (bankOpen_r & ~(rdApClose | preClose | recDone))
                             | (isAct ? newHot : 4'h0);

   for (genvar b = 0; b < 4; b++) begin : gBank
      assign recDone[b] = wrRec_r[b] == `SDB_REC_W'(1);
      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) wrRec_r[b] <= '0;
         else if (recStart[b]) wrRec_r[b] <= `SDB_REC_W'(WR_CYC);
         else if (wrRec_r[b] != '0) wrRec_r[b] <= wrRec_r[b] - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         bankOpen_r <= '0;
         refRow_r   <= '0;
         modeReg_r  <= `SDB_MODE_RESET;
      end else begin
         bankOpen_r <= bankOpen_nxt;
         if (isARef || isSRef) refRow_r <= refRow_r + REF_ONE;
         if (isMrs) modeReg_r <= addrPins;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (isAct) actRow_r[bankSelectBits] <= addrPins;
   end

   // -----------------------------------------------------------------
   // Power states
   // -----------------------------------------------------------------
   wire idleAll = bankOpen_r == 4'h0 && !bActive_r;
   always_comb begin
      pwr_nxt = pwr_r;
      case (pwr_r)
         PWR_RUN: begin
            if (isSRef) pwr_nxt = PWR_SELF;
            else if (ckePrev_r && !cke && idleAll) pwr_nxt = PWR_DOWN;
         end
         default: begin
            if (cke) pwr_nxt = PWR_RUN;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pwr_r     <= PWR_RUN;
         ckePrev_r <= 1'b0;
      end else begin
         pwr_r     <= pwr_nxt;
         ckePrev_r <= cke;
      end
   end

   // -----------------------------------------------------------------
   // Write path through the buffer
   // -----------------------------------------------------------------
   wire engWr = beatNow && bWrite_r && !rwCmd && !stopHit;
   wire wrBeat = isWr || engWr;
   wire bufPush = wrBeat && !dataMask;
   wire [MEM_AW-1:0] wrAddr = isWr ?
      memIdx(bankSelectBits, actRow_r[bankSelectBits], colIn) :
      memIdx(bBank_r, actRow_r[bBank_r], curCol);
   wire rdBeat = beatNow && !bWrite_r;
   wire bufValid;
   wire [MEM_AW+DQ_W-1:0] bufData;

   sdb_fifo #(.WIDTH(MEM_AW + DQ_W), .DEPTH(BUF_DEPTH)) uBuf (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .inValid  (bufPush),
      .inReady  (wrBufReady),
      .inData   ({wrAddr, dqIn}),
      .outValid (bufValid),
      .outReady (!rdBeat),
      .outData  (bufData)
   );

   always_ff @(posedge sys_clk) begin
      if (bufValid && !rdBeat) mem[bufData[MEM_AW+DQ_W-1:DQ_W]] <=
         bufData[DQ_W-1:0];
   end

   // -----------------------------------------------------------------
   // Read path and output mask
   // -----------------------------------------------------------------
   wire [MEM_AW-1:0] rdAddr = memIdx(bBank_r, actRow_r[bBank_r], curCol);
   wire selVld = latency3 ? vld1_r : vld0_r;
   wire [DQ_W-1:0] selDat = latency3 ? pipe1_r : pipe0_r;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         vld0_r   <= 1'b0;
         vld1_r   <= 1'b0;
         pipe0_r  <= '0;
         pipe1_r  <= '0;
         dqOut_r  <= '0;
         outVld_r <= 1'b0;
         dqOe_r   <= 1'b0;
         dqmD1_r  <= 1'b0;
         dqmD2_r  <= 1'b0;
      end else begin
         vld0_r   <= rdBeat;
         pipe0_r  <= mem[rdAddr];
         vld1_r   <= vld0_r;
         pipe1_r  <= pipe0_r;
         dqOut_r  <= selDat;
         outVld_r <= selVld;
         dqmD1_r  <= dataMask;
         dqmD2_r  <= dqmD1_r;
         dqOe_r   <= selVld && !dqmD2_r;
      end
   end

   assign dqOut = dqOut_r;
   assign dqOe = dqOe_r;
   assign bankOpen = bankOpen_r;
   assign operatingModeSetup = modeReg_r;
   assign refreshCount = refRow_r;
   assign powerState = pwr_r;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   a_read_lat_two: assert property (isRd && cke && !latency3 |-> ##3 outVld_r)
      else $error("read data missing two clocks after read");
   a_read_lat_three: assert property (isRd && cke && latency3 |-> ##4 outVld_r)
      else $error("read data missing three clocks after read");
   a_mask_hiz: assert property (dataMask |-> ##DQZ_SEEN !dqOe)
      else $error("outputs still driven after read mask");
   a_write_mask: assert property (wrBeat && dataMask |-> !bufPush)
      else $error("masked write word was stored");
   a_pre_all: assert property (isPre && apFlag |=> bankOpen_r == 4'h0)
      else $error("precharge all left a bank open");
   a_pre_one: assert property (isPre && !apFlag |=>
      !bankOpen_r[$past(bankSelectBits)] && bankOpen_r ==
      ($past(bankOpen_r) & ~$past(newHot)))
      else $error("single precharge closed the wrong banks");
   a_refresh_step: assert property (isARef |=>
      refRow_r == $past(refRow_r) + REF_ONE && bankOpen_r == $past(bankOpen_r))
      else $error("refresh counter did not advance");
   a_stop_drop: assert property (isStop |-> !bufPush ##1 !bActive_r)
      else $error("write burst continued past stop");
   a_wrap_block: assert property (beatNow && !interleaved &&
      blCode == `SDB_BL_4 |-> curCol[COL_W-1:2] == bStart_r[COL_W-1:2])
      else $error("sequential burst left its block");
   a_interleave8: assert property (beatNow && interleaved &&
      blCode == `SDB_BL_8 |-> curCol[2:0] == (bStart_r[2:0] ^ bIdx_r[2:0]))
      else $error("interleaved column order wrong");
   a_ap_write_close: assert property (recStart[1] && !isPre && !isAct |->
      ##WR_CYC bankOpen_r[1] ##1 !bankOpen_r[1])
      else $error("auto precharge after write at wrong time");
   a_selfref_hold: assert property (pwr_r == PWR_SELF && !cke |=>
      $stable(bankOpen_r) && $stable(modeReg_r) && pwr_r == PWR_SELF)
      else $error("state changed during self refresh");
   a_burst_restart: assert property (isRd |=> bActive_r && bIdx_r == '0)
      else $error("read did not restart the burst");
endmodule : sdb_core

// >>> verif/sdb_ctrl_model.sv
// Memory controller model driving the command and data pins
`timescale 1ns/1ps
module sdb_ctrl_model (
   // Clock
   input  wire logic          sys_clk,
   // Command pins
   output logic               cke,
   output logic               chipSel_n,
   output logic               rowStrobe_n,
   output logic               colStrobe_n,
   output logic               writeSel_n,
   output logic               dataMask,
   output sdb_pkg::sdb_bank_t bankSelectBits,
   output logic [12:0]        addrPins,
   // Data pins
   output logic [7:0]         dqIn
);
   import sdb_pkg::*;
   // ---------------------------------------------------------------
   // Pin drivers
   // ---------------------------------------------------------------
   logic ckeLvl = 1'b1;
   initial begin
      cke            = 1'b1;
      chipSel_n      = 1'b0;
      {rowStrobe_n, colStrobe_n, writeSel_n} = 3'h7;
      dataMask       = 1'b0;
      bankSelectBits = 2'h0;
      addrPins       = 13'h0000;
      dqIn           = 8'h00;
   end
   // One command slot per clock; a released data bus shows the
   // inverse of its last value so no stale word can pass for data
   task automatic step(input logic [2:0] rcw, input sdb_bank_t ba,
                       input logic [12:0] a, input logic dv,
                       input logic [7:0] d, input logic m);
      @(posedge sys_clk);
      #1;
      {rowStrobe_n, colStrobe_n, writeSel_n} = rcw;
      cke            = ckeLvl;
      bankSelectBits = ba;
      addrPins       = a;
      dqIn           = dv ? d : ~dqIn;
      dataMask       = m;
   endtask : step
endmodule : sdb_ctrl_model

// >>> verif/test_sdb_core.sv
// Self-checking bench for the SDRAM command core
`timescale 1ns/1ps
module test_sdb_core;
   import sdb_pkg::*;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   localparam logic [2:0] NOP = 3'h7, ACT = 3'h3, RD = 3'h5, WR = 3'h4;
   localparam logic [2:0] PRE = 3'h2, MRS = 3'h0, REF = 3'h1, STP = 3'h6;
   logic        sys_clk, reset_n, cke, chipSel_n, rowStrobe_n;
   logic        colStrobe_n, writeSel_n, dataMask, dqOe;
   sdb_bank_t   bankSelectBits;
   logic [12:0] addrPins, operatingModeSetup;
   logic [7:0]  dqIn, dqOut;
   logic [3:0]  bankOpen;
   logic [14:0] refreshCount;
   sdb_pwr_t    powerState;
   int          errors, cmp_count, cycles;
   logic [7:0]  exp [8];

   sdb_core u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .cke(cke),
      .chipSel_n(chipSel_n), .rowStrobe_n(rowStrobe_n),
      .colStrobe_n(colStrobe_n), .writeSel_n(writeSel_n),
      .dataMask(dataMask), .bankSelectBits(bankSelectBits),
      .addrPins(addrPins), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
      .wrBufReady(), .bankOpen(bankOpen),
      .operatingModeSetup(operatingModeSetup),
      .refreshCount(refreshCount), .powerState(powerState));
   sdb_ctrl_model u_ctrl (.sys_clk(sys_clk), .cke(cke),
      .chipSel_n(chipSel_n), .rowStrobe_n(rowStrobe_n),
      .colStrobe_n(colStrobe_n), .writeSel_n(writeSel_n),
      .dataMask(dataMask), .bankSelectBits(bankSelectBits),
      .addrPins(addrPins), .dqIn(dqIn));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      cmp_count++;
      if (got !== want) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask : chk
   task automatic nop(input int n);
      repeat (n) u_ctrl.step(NOP, 2'h0, 13'h0000, 1'b0, 8'h00, 1'b0);
   endtask : nop
   task automatic cmd(input logic [2:0] c, input sdb_bank_t b,
                      input logic [12:0] a);
      u_ctrl.step(c, b, a, 1'b0, 8'h00, 1'b0);
   endtask : cmd
   // Write burst; beat st carries a burst stop instead
   task automatic wr(input sdb_bank_t b, input logic [12:0] a, input int n,
                     input logic [7:0] d0, input logic [7:0] mk, input int st);
      for (int i = 0; i < n; i++) begin
         u_ctrl.step(i == 0 ? WR : (i == st ? STP : NOP), b, a, 1'b1,
                     d0 + 8'(i), mk[i]);
      end
      nop(1);
   endtask : wr
   // Read burst; mk is the mask per slot, off marks words driven off
   task automatic rd(input sdb_bank_t b, input logic [12:0] a, input int lat,
                     input int n, input logic [15:0] mk, input logic [7:0] off);
      cmd(RD, b, a);
      for (int i = 0; i < lat + n; i++) begin
         u_ctrl.step(NOP, b, 13'h0000, 1'b0, 8'h00, mk[i]);
         if (i >= lat) begin
            chk(16'(dqOe), 16'(!off[i-lat]));
            if (!off[i-lat]) chk(16'(dqOut), 16'(exp[i-lat]));
         end
      end
   endtask : rd
   task automatic complete_run();
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run
   // ---------------------------------------------------------------
   // Clock, timeout and test sequence
   // ---------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         complete_run();
      end
   end
   initial begin
      reset_n = 1'b0;
      repeat (20) @(posedge sys_clk);
      #1;
      reset_n = 1'b1;
      chk(16'(operatingModeSetup), 16'h0020);
      chk(16'(bankOpen), 16'h0000);
      chk(16'(powerState), 16'(PWR_RUN));
      nop(2);
      cmd(REF, 2'h0, 13'h0000);
      nop(1);
      chk(16'(refreshCount), 16'h0001);
      nop(14);
      cmd(MRS, 2'h0, 13'h003B);
      nop(2);
      chk(16'(operatingModeSetup), 16'h003B);
      cmd(ACT, 2'h1, 13'h0005);
      nop(1);
      chk(16'(bankOpen), 16'h0002);
      nop(3);
      wr(2'h1, 13'h0000, 8, 8'hA0, 8'h00, -1);
      nop(20);
      for (int i = 0; i < 8; i++) exp[i] = 8'hA0 | 8'(2 ^ i);
      rd(2'h1, 13'h0002, 3, 8, 16'h0000, 8'h00);
      cmd(PRE, 2'h1, 13'h0000);
      nop(1);
      chk(16'(bankOpen), 16'h0000);
      nop(3);
      cmd(MRS, 2'h0, 13'h0022);
      nop(2);
      cmd(ACT, 2'h1, 13'h0005);
      nop(4);
      for (int i = 0; i < 4; i++) exp[i] = 8'hA4 + 8'(i);
      rd(2'h1, 13'h0004, 2, 4, 16'h0002, 8'h04);
      for (int i = 0; i < 4; i++) exp[i] = 8'hA4 | 8'((1 + i) % 4);
      rd(2'h1, 13'h0405, 2, 4, 16'h0000, 8'h00);
      chk(16'(bankOpen), 16'h0000);
      cmd(ACT, 2'h1, 13'h0005);
      nop(4);
      wr(2'h1, 13'h0008, 4, 8'h10, 8'h00, -1);
      wr(2'h1, 13'h0008, 4, 8'h20, 8'h02, 2);
      chk(16'(bankOpen), 16'h0002);
      nop(20);
      for (int i = 0; i < 4; i++) exp[i] = (i == 0) ? 8'h20 : 8'h10 + 8'(i);
      rd(2'h1, 13'h0008, 2, 4, 16'h0000, 8'h00);
      wr(2'h1, 13'h040C, 4, 8'h40, 8'h00, -1);
      nop(2);
      chk(16'(bankOpen), 16'h0002);
      nop(1);
      chk(16'(bankOpen), 16'h0000);
      cmd(ACT, 2'h1, 13'h0005);
      nop(4);
      wr(2'h1, 13'h0010, 4, 8'h30, 8'h00, -1);
      cmd(PRE, 2'h1, 13'h0000);
      nop(2);
      cmd(MRS, 2'h0, 13'h00A2);
      nop(2);
      cmd(ACT, 2'h1, 13'h0005);
      nop(4);
      wr(2'h1, 13'h0010, 4, 8'h50, 8'h00, -1);
      nop(20);
      for (int i = 0; i < 4; i++) exp[i] = (i == 0) ? 8'h50 : 8'h30 + 8'(i);
      rd(2'h1, 13'h0010, 2, 4, 16'h0000, 8'h00);
      cmd(PRE, 2'h1, 13'h0000);
      nop(1);
      cmd(ACT, 2'h2, 13'h0001);
      nop(3);
      cmd(ACT, 2'h3, 13'h0002);
      nop(4);
      chk(16'(bankOpen), 16'h000C);
      cmd(PRE, 2'h0, 13'h0400);
      nop(1);
      chk(16'(bankOpen), 16'h0000);
      nop(4);
      u_ctrl.ckeLvl = 1'b0;
      nop(2);
      cmd(ACT, 2'h0, 13'h0001);
      nop(1);
      chk(16'(powerState), 16'(PWR_DOWN));
      chk(16'(bankOpen), 16'h0000);
      u_ctrl.ckeLvl = 1'b1;
      nop(2);
      chk(16'(powerState), 16'(PWR_RUN));
      nop(2);
      u_ctrl.ckeLvl = 1'b0;
      cmd(REF, 2'h0, 13'h0000);
      nop(1);
      chk(16'(powerState), 16'(PWR_SELF));
      chk(16'(refreshCount), 16'h0002);
      nop(3);
      u_ctrl.ckeLvl = 1'b1;
      nop(2);
      chk(16'(powerState), 16'(PWR_RUN));
      nop(14);
      complete_run();
   end
endmodule : test_sdb_core
